/* File: src/mbsc_top.sv */
/*
  mbsc_top: bank control of the multiply-accumulate unit, an AHB-Lite
  register slave holding two 40-bit accumulator banks, their states,
  the condition register and a masked interrupt.
  assumes the arithmetic engine sits on the same clock, takes a one-cycle
  start pulse with the bank number, and answers with a done pulse and
  its 40-bit result.
*/
//
// Behaviour
// (RQ1) top accumulator byte shows bits 39:32 of the cpu-side bank, read and write.
// (RQ2) reading the top accumulator byte empties the cpu-side bank.
// (RQ3) that read swaps banks when engine side done: cpu done, engine empty.
// (RQ4) writing the top accumulator byte moves cpu-side bank from empty to ready.
// (RQ5) a ready bank is swapped to an idle engine and computing starts.
// (RQ6) writing 80h to condition swaps when engine done and cpu empty.
// (RQ7) two banks 0 and 1; condition bit 4 names the cpu-side one.
// (RQ8) with both banks empty the cpu side returns to bank 0.
// (RQ9) bits 3:2 give engine side: 00 empty, 10 busy, 11 done.
// (RQ10) bits 1:0 give cpu side: 00 empty, 01 ready, 11 done.
// (RQ11) finished engine work stores result in its bank and marks it done.
// (RQ12) cpu-side done means an unread result sits in its accumulator.
// (RQ13) lower four accumulator bytes are separate registers, lowest holds bits 7:0.
// (RQ14) other condition writes leave bank states and selection alone.
`timescale 1ns/100ps
`default_nettype none

module mbsc_top
  import mbsc_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic engine_done,
  input wire logic [39:0] engine_result,
  output logic engine_start,
  output logic engine_bank,
  output logic irq
);

  function automatic logic [1:0] mbsc_code(input mbsc_bank_type st, input logic eng);
    logic [1:0] c;
    c = 2'h0;
    case (st)
      MBSC_EMPTY: c = 2'h0;
      MBSC_READY: c = 2'h1;
      MBSC_BUSY: c = 2'h2;
      MBSC_DONE: c = 2'h3;
      default: c = 2'h0;
    endcase
    // codes 01 on the engine side and 10 on the cpu side never occur
    if (eng && c == 2'h1)
      c = 2'h0;
    if (!eng && c == 2'h2)
      c = 2'h0;
    return c;
  endfunction

  mbsc_state_type r;
  mbsc_state_type n;
  logic addr_take;
  logic rd_fire;
  logic wr_fire;
  logic top_rd;
  logic top_wr;
  logic cond_wr;
  logic [1:0] ev;
  logic [7:0] cond_val;
  logic [7:0] cpu_top;
  logic [7:0] wr_byte;

  assign addr_take = ce && hsel && hready && htrans == MBSC_HTRANS_NONSEQ;
  // reads get one wait state so that a write just before is already visible
  assign rd_fire = ce && r.ph_valid && !r.ph_write && !r.hready;
  assign wr_fire = ce && r.ph_valid && r.ph_write;
  assign top_rd = rd_fire && r.ph_hit && r.ph_idx == MBSC_IDX_ACCUM_TOP;
  assign top_wr = wr_fire && r.ph_hit && r.ph_idx == MBSC_IDX_ACCUM_TOP;
  assign cond_wr = wr_fire && r.ph_hit && r.ph_idx == MBSC_IDX_CONDITION;
  // plain views for the properties, so that $past sees whole signals
  assign cpu_top = r.acc[r.sel][39:32];
  assign wr_byte = hwdata[7:0];

  always_comb
  begin
    cond_val = MBSC_CONDITION_RESET;
    cond_val[MBSC_BANK_BIT] = r.sel; // [RQ7]
    cond_val[MBSC_ENG_LSB +: 2] = mbsc_code(r.eng_st, 1'b1); // [RQ9]
    cond_val[MBSC_CPU_LSB +: 2] = mbsc_code(r.cpu_st, 1'b0); // [RQ10]
  end

  always_comb
  begin
    n = r;
    ev = 2'h0;
    n.start = 1'b0;
    n.hresp = 1'b0;
    if (rd_fire || wr_fire)
      n.ph_valid = 1'b0;
    if (addr_take)
    begin
      n.ph_valid = 1'b1;
      n.ph_write = hwrite;
      // only aligned whole words inside the register window are mapped
      n.ph_hit = haddr[31:10] == 22'h000000 && haddr[1:0] == 2'h0 &&
                 hsize == MBSC_HSIZE_WORD;
      n.ph_idx = haddr[9:2];
      if (!hwrite)
        n.hready = 1'b0;
    end

    // engine completion comes first so a same-cycle read can swap it in
    if (engine_done && n.eng_st == MBSC_BUSY)
    begin
      n.acc[!n.sel] = engine_result; // [RQ11]
      n.eng_st = MBSC_DONE; // [RQ11]
      ev[MBSC_EV_DONE] = 1'b1;
    end

    if (rd_fire)
    begin
      n.hready = 1'b1;
      n.hrdata = 32'h00000000;
      if (r.ph_hit)
      begin
        for (int k = 0; k < MBSC_ACC_BYTES; k++)
        begin
          if (r.ph_idx == 8'(MBSC_IDX_AC0 + k))
            n.hrdata[7:0] = r.acc[r.sel][k * 8 +: 8]; // [RQ1] [RQ13] [RQ12]
        end
        case (r.ph_idx)
          MBSC_IDX_CONDITION: n.hrdata[7:0] = cond_val;
          MBSC_IDX_IRQ_STATUS: n.hrdata[1:0] = r.irq_st;
          MBSC_IDX_IRQ_MASK: n.hrdata[1:0] = r.irq_mask;
          default: n.hrdata[7:0] = n.hrdata[7:0];
        endcase
      end
    end

    if (wr_fire && r.ph_hit)
    begin
      for (int k = 0; k < MBSC_ACC_BYTES; k++)
      begin
        if (r.ph_idx == 8'(MBSC_IDX_AC0 + k))
          n.acc[n.sel][k * 8 +: 8] = hwdata[7:0]; // [RQ1] [RQ13]
      end
      if (r.ph_idx == MBSC_IDX_IRQ_MASK)
        n.irq_mask = hwdata[1:0];
      if (r.ph_idx == MBSC_IDX_IRQ_STATUS)
        n.irq_st = n.irq_st & ~hwdata[1:0];
    end

    if (top_wr && n.cpu_st == MBSC_EMPTY)
      n.cpu_st = MBSC_READY; // [RQ4]

    if (top_rd)
    begin
      n.cpu_st = MBSC_EMPTY; // [RQ2]
      if (n.eng_st == MBSC_DONE)
      begin
        n.sel = !n.sel; // [RQ3]
        n.cpu_st = MBSC_DONE; // [RQ3]
        n.eng_st = MBSC_EMPTY; // [RQ3]
      end
    end

    // any other value or state leaves the banks untouched
    if (cond_wr && hwdata[7:0] == MBSC_SWAP_CMD && n.eng_st == MBSC_DONE &&
        n.cpu_st == MBSC_EMPTY) // [RQ14]
    begin
      n.sel = !n.sel; // [RQ6]
      n.cpu_st = MBSC_DONE; // [RQ6]
      n.eng_st = MBSC_EMPTY; // [RQ6]
    end

    // a ready bank starts only if the engine side is empty here; a later swap marks the cpu side done and drops it
    if (n.cpu_st == MBSC_READY && n.eng_st == MBSC_EMPTY)
    begin
      n.sel = !n.sel; // [RQ5]
      n.eng_st = MBSC_BUSY; // [RQ5]
      n.cpu_st = MBSC_EMPTY; // [RQ5]
      n.start = 1'b1; // [RQ5]
      ev[MBSC_EV_START] = 1'b1;
    end

    if (n.cpu_st == MBSC_EMPTY && n.eng_st == MBSC_EMPTY)
      n.sel = 1'b0; // [RQ8]
    n.eng_bank = !n.sel;

    // a new event beats a clear written in the same cycle
    n.irq_st = n.irq_st | ev;
    n.irq = |(r.irq_st & r.irq_mask);
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      r <= MBSC_STATE_RESET;
    else if (ce)
      r <= n;
  end

  assign hreadyout = r.hready;
  assign hresp = r.hresp;
  assign hrdata = r.hrdata;
  assign engine_start = r.start;
  assign engine_bank = r.eng_bank;
  assign irq = r.irq;

  property p_top_read_empty;
    @(posedge clk) disable iff (sys_rst)
    (top_rd && r.eng_st != MBSC_DONE && !(engine_done && r.eng_st == MBSC_BUSY))
      |=> r.cpu_st == MBSC_EMPTY;
  endproperty
  a_top_read_empty: assert property (p_top_read_empty) // [RQ2]
    else $error("top byte read did not empty the cpu bank");

  property p_top_read_swap;
    @(posedge clk) disable iff (sys_rst)
    (top_rd && r.eng_st == MBSC_DONE)
      |=> r.cpu_st == MBSC_DONE && r.eng_st == MBSC_EMPTY && r.sel != $past(r.sel);
  endproperty
  a_top_read_swap: assert property (p_top_read_swap) // [RQ3]
    else $error("top byte read with engine done did not swap");

  property p_top_write_ready;
    @(posedge clk) disable iff (sys_rst)
    (top_wr && r.cpu_st == MBSC_EMPTY && r.eng_st == MBSC_BUSY && !engine_done)
      |=> r.cpu_st == MBSC_READY && r.eng_st == MBSC_BUSY && !engine_start;
  endproperty
  a_top_write_ready: assert property (p_top_write_ready) // [RQ4]
    else $error("top byte write did not mark the cpu bank ready");

  property p_top_write_start;
    @(posedge clk) disable iff (sys_rst)
    (top_wr && r.cpu_st == MBSC_EMPTY && r.eng_st == MBSC_EMPTY)
      |=> engine_start && r.eng_st == MBSC_BUSY && r.cpu_st == MBSC_EMPTY &&
          engine_bank == $past(r.sel);
  endproperty
  a_top_write_start: assert property (p_top_write_start) // [RQ5]
    else $error("write to an idle engine did not start it");

  property p_start_pulse;
    @(posedge clk) disable iff (sys_rst)
    (ce && engine_start) |-> r.eng_st == MBSC_BUSY ##1 !engine_start;
  endproperty
  a_start_pulse: assert property (p_start_pulse) // [RQ5]
    else $error("engine start without a busy engine bank");

  property p_cond_swap;
    @(posedge clk) disable iff (sys_rst)
    (cond_wr && hwdata[7:0] == 8'h80 && r.eng_st == MBSC_DONE && r.cpu_st == MBSC_EMPTY)
      |=> r.cpu_st == MBSC_DONE && r.eng_st == MBSC_EMPTY && r.sel != $past(r.sel);
  endproperty
  a_cond_swap: assert property (p_cond_swap) // [RQ6]
    else $error("swap command did not swap the banks");

  property p_cond_ignore;
    @(posedge clk) disable iff (sys_rst)
    (cond_wr && hwdata[7:0] != 8'h80 && !engine_done && r.cpu_st != MBSC_READY &&
     !(r.eng_st == MBSC_EMPTY && r.cpu_st == MBSC_EMPTY))
      |=> $stable(r.cpu_st) && $stable(r.eng_st) && $stable(r.sel);
  endproperty
  a_cond_ignore: assert property (p_cond_ignore) // [RQ14]
    else $error("condition write of another value changed the banks");

  property p_home_bank;
    @(posedge clk) disable iff (sys_rst)
    (r.cpu_st == MBSC_EMPTY && r.eng_st == MBSC_EMPTY) |-> !r.sel && engine_bank;
  endproperty
  a_home_bank: assert property (p_home_bank) // [RQ8]
    else $error("both banks empty but cpu side is not bank 0");

  property p_engine_done;
    @(posedge clk) disable iff (sys_rst)
    (ce && engine_done && r.eng_st == MBSC_BUSY && !top_rd && !cond_wr)
      |=> r.eng_st == MBSC_DONE && r.acc[!r.sel] == $past(engine_result);
  endproperty
  a_engine_done: assert property (p_engine_done) // [RQ11]
    else $error("engine completion not stored in its bank");

  property p_cond_read;
    @(posedge clk) disable iff (sys_rst)
    (rd_fire && r.ph_hit && r.ph_idx == MBSC_IDX_CONDITION)
      |=> hreadyout && hrdata[31:5] == 27'h0 && hrdata[4] == $past(r.sel) &&
          hrdata[3:2] != 2'h1 && hrdata[1:0] != 2'h2;
  endproperty
  a_cond_read: assert property (p_cond_read) // [RQ7] [RQ9] [RQ10]
    else $error("condition read shows a wrong bank or code");

  property p_read_wait;
    @(posedge clk) disable iff (sys_rst)
    (addr_take && !hwrite) |=> !hreadyout ##1 hreadyout;
  endproperty
  a_read_wait: assert property (p_read_wait) // [RQ1]
    else $error("read answer not given after one wait state");

  property p_irq_level;
    @(posedge clk) disable iff (sys_rst)
    (ce && (|(r.irq_st & r.irq_mask))) |=> irq;
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("unmasked event did not raise the interrupt");

  property p_top_write_data;
    @(posedge clk) disable iff (sys_rst)
    top_wr |=> r.acc[$past(r.sel)][39:32] == $past(wr_byte);
  endproperty
  a_top_write_data: assert property (p_top_write_data) // [RQ1]
    else $error("top byte write did not land in the cpu bank");

  property p_low_write_data;
    @(posedge clk) disable iff (sys_rst)
    (wr_fire && r.ph_hit && r.ph_idx == MBSC_IDX_AC0)
      |=> r.acc[$past(r.sel)][7:0] == $past(wr_byte);
  endproperty
  a_low_write_data: assert property (p_low_write_data) // [RQ13]
    else $error("lowest byte write did not land in bits 7:0");

  property p_top_read_data;
    @(posedge clk) disable iff (sys_rst)
    top_rd |=> hrdata == {24'h000000, $past(cpu_top)};
  endproperty
  a_top_read_data: assert property (p_top_read_data) // [RQ1] [RQ12]
    else $error("top byte read returned the wrong bank bits");

  property p_state_legal;
    @(posedge clk) disable iff (sys_rst)
    r.eng_st != MBSC_READY && r.cpu_st != MBSC_BUSY;
  endproperty
  a_state_legal: assert property (p_state_legal) // [RQ9] [RQ10]
    else $error("bank state outside its legal set");

  property p_engine_bank;
    @(posedge clk) disable iff (sys_rst)
    engine_bank != r.sel;
  endproperty
  a_engine_bank: assert property (p_engine_bank) // [RQ7]
    else $error("engine bank equals the cpu-side bank");

  property p_done_event;
    @(posedge clk) disable iff (sys_rst)
    (ce && engine_done && r.eng_st == MBSC_BUSY) |=> r.irq_st[MBSC_EV_DONE];
  endproperty
  a_done_event: assert property (p_done_event)
    else $error("engine completion did not set its event bit");

endmodule

`default_nettype wire

/* File: pkg/mbsc_pkg.sv */
/*
  mbsc_pkg: constants, bank states and the state record of the
  double-banked multiply-accumulate control block.
  assumes a single 125 MHz system clock and word-aligned register slots.
*/
`default_nettype none

package mbsc_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] MBSC_IDX_AC0 = 8'he8;
  localparam logic [7:0] MBSC_IDX_ACCUM_TOP = 8'hec;
  localparam logic [7:0] MBSC_IDX_CONDITION = 8'hed;
  localparam logic [7:0] MBSC_IDX_IRQ_STATUS = 8'hee;
  localparam logic [7:0] MBSC_IDX_IRQ_MASK = 8'hef;
  localparam int MBSC_ACC_BYTES = 5;

  localparam logic [7:0] MBSC_SWAP_CMD = 8'h80;
  localparam logic [2:0] MBSC_HSIZE_WORD = 3'h2;
  localparam logic [1:0] MBSC_HTRANS_NONSEQ = 2'h2;

  // condition register fields
  localparam int MBSC_BANK_BIT = 4;
  localparam int MBSC_ENG_LSB = 2;
  localparam int MBSC_CPU_LSB = 0;

  // interrupt event bits
  localparam int MBSC_EV_DONE = 0;
  localparam int MBSC_EV_START = 1;

  localparam logic [7:0] MBSC_CONDITION_RESET = 8'h00;
  localparam logic [1:0] MBSC_IRQ_MASK_RESET = 2'h0;

  typedef enum logic [3:0]
  {
    MBSC_EMPTY = 4'b0001,
    MBSC_READY = 4'b0010,
    MBSC_BUSY = 4'b0100,
    MBSC_DONE = 4'b1000
  } mbsc_bank_type;

  typedef struct packed
  {
    logic ph_valid;
    logic ph_write;
    logic ph_hit;
    logic [7:0] ph_idx;
    logic hready;
    logic hresp;
    logic [31:0] hrdata;
    mbsc_bank_type cpu_st;
    mbsc_bank_type eng_st;
    logic sel;
    logic eng_bank;
    logic [1:0][39:0] acc;
    logic [1:0] irq_st;
    logic [1:0] irq_mask;
    logic irq;
    logic start;
  } mbsc_state_type;

  localparam mbsc_state_type MBSC_STATE_RESET = '{
    ph_valid: 1'b0, ph_write: 1'b0, ph_hit: 1'b0, ph_idx: 8'h00,
    hready: 1'b1, hresp: 1'b0, hrdata: 32'h00000000,
    cpu_st: MBSC_EMPTY, eng_st: MBSC_EMPTY,
    sel: MBSC_CONDITION_RESET[MBSC_BANK_BIT], eng_bank: 1'b1,
    acc: 80'h00000000000000000000,
    irq_st: 2'h0, irq_mask: MBSC_IRQ_MASK_RESET, irq: 1'b0, start: 1'b0};

endpackage

`default_nettype wire

/* File: tb/mbsc_engine_model.sv */
/*
  mbsc_engine_model: arithmetic engine behind the bank control.
  assumes the block's clock and reset; delay is held steady per calculation.
*/
`timescale 1ns/100ps
`default_nettype none

module mbsc_engine_model
#(
  parameter logic [39:0] RESULT = 40'h9876543210
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic engine_start,
  input wire logic [7:0] delay,
  output logic engine_done,
  output logic [39:0] engine_result
);
  logic busy;
  logic [7:0] cnt;
  // outside the done pulse the result lines show a wrong pattern
  assign engine_result = engine_done ? RESULT : ~RESULT;
  always_ff @(posedge clk)
  begin
    engine_done <= 1'b0;
    if (sys_rst)
    begin
      busy <= 1'b0;
      cnt <= 8'h00;
    end
    else if (engine_start && !busy)
    begin
      busy <= 1'b1;
      cnt <= delay;
    end
    else if (busy && cnt == 8'h00)
    begin
      busy <= 1'b0;
      engine_done <= 1'b1;
    end
    else if (busy)
      cnt <= cnt - 8'h01;
  end
endmodule

`default_nettype wire

/* File: tb/tb.sv */
/*
  tb: bus-level tests of the bank control over AHB-Lite.
  assumes the engine model answers each start pulse after a set delay.
*/
`timescale 1ns/100ps
`default_nettype none

module tb
  import mbsc_pkg::*;
;
  localparam logic [39:0] RES = 40'h9876543210;
  localparam logic [31:0] A_TOP = 32'h3b0;
  localparam logic [31:0] A_CND = 32'h3b4;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [7:0] eng_delay = 8'h3c;
  logic hreadyout, hresp, engine_done, engine_start, engine_bank, irq;
  logic [31:0] hrdata;
  logic [39:0] engine_result;
  logic [31:0] scratch;
  int error_cnt = 0;
  int checks = 0;

  mbsc_top uut (.clk(clk), .sys_rst(sys_rst), .ce(1'b1), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(MBSC_HSIZE_WORD), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .engine_done(engine_done), .engine_result(engine_result),
    .engine_start(engine_start), .engine_bank(engine_bank), .irq(irq));
  mbsc_engine_model #(.RESULT(RES)) engine (.clk(clk), .sys_rst(sys_rst),
    .engine_start(engine_start), .delay(eng_delay), .engine_done(engine_done),
    .engine_result(engine_result));

  initial
  begin
    forever #4 clk = ~clk;
  end

  task conclude;
    $display("comparisons %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // level outputs are looked at mid-cycle, one and a half cycles after the cause
  task chkb(input logic got_sel, input logic exp);
    repeat (2) @(negedge clk);
    chk({31'h0, got_sel ? irq : engine_bank}, {31'h0, exp});
  endtask

  // ready and data are read at the falling edge, steady up to the next rise
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
    output logic [31:0] r);
    logic rdy;
    logic resp;
    @(posedge clk);
    htrans <= MBSC_HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    do
    begin
      @(negedge clk);
      rdy = hreadyout;
      @(posedge clk);
    end while (rdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do
    begin
      @(negedge clk);
      rdy = hreadyout;
      r = hrdata;
      resp = hresp;
      @(posedge clk);
    end while (rdy !== 1'b1);
    chk({31'h0, resp}, 32'h0);
  endtask

  task wr(input logic [31:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, scratch);
  endtask

  task rd(input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0, scratch);
    chk(scratch, exp);
  endtask

  // a missing completion counts as a mismatch instead of slipping through
  task wait_done;
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < 300; i++)
    begin
      @(negedge clk);
      if (engine_done === 1'b1)
      begin
        seen = 1'b1;
        break;
      end
    end
    chk({31'h0, seen}, 32'h1);
  endtask

  initial
  begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rd(A_CND, 32'h00);
    rd(32'h0, 32'h0);
    wr(A_TOP, 32'h5a);
    rd(A_CND, 32'h18);
    chkb(1'b0, 1'b0);
    wait_done;
    rd(A_CND, 32'h1c);
    rd(32'h3b8, 32'h3);
    chkb(1'b1, 1'b0);
    wr(32'h3bc, 32'h1);
    chkb(1'b1, 1'b1);
    wr(32'h3b8, 32'h1);
    chkb(1'b1, 1'b0);
    wr(A_CND, 32'h40);
    wr(32'h0, 32'h80);
    rd(A_CND, 32'h1c);
    wr(A_CND, 32'h80);
    rd(A_CND, 32'h03);
    for (int i = 0; i < 4; i++)
      rd(32'h3a0 + 4 * i, {24'h0, RES[8 * i +: 8]});
    wr(32'h3a0, 32'h77);
    rd(32'h3a0, 32'h77);
    wr(A_TOP, 32'ha5);
    rd(A_CND, 32'h03);
    rd(A_TOP, 32'ha5);
    rd(A_CND, 32'h00);
    eng_delay <= 8'h00;
    wr(A_TOP, 32'h11);
    wait_done;
    rd(A_CND, 32'h1c);
    rd(A_TOP, 32'h0);
    rd(A_CND, 32'h03);
    rd(A_TOP, {24'h0, RES[39:32]});
    rd(A_CND, 32'h00);
    // a second bank is loaded while the engine is still busy
    eng_delay <= 8'h14;
    wr(A_TOP, 32'h22);
    wr(A_TOP, 32'h33);
    rd(A_CND, 32'h19);
    wait_done;
    rd(A_CND, 32'h1d);
    wr(A_CND, 32'h80);
    rd(A_CND, 32'h1d);
    rd(A_TOP, 32'h33);
    rd(A_CND, 32'h03);
    rd(A_TOP, {24'h0, RES[39:32]});
    rd(A_CND, 32'h00);
    conclude;
  end

  initial
  begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    conclude;
  end
endmodule

`default_nettype wire
